/* core/cfglk_top.sv */
// Operation
// - Power-on reset leaves the bank locked.
// - Locked bank ignores writes, still reads.
// - Both keys correct before unlocking.
// - Open bank writes writable words only.
// - Wrong key value relocks the bank.
// - One key pair, one shared lock.
`timescale 1ns/1ps
`include "cfglk_map.svh"

module cfglk_top
  import cfglk_pkg::*;
#(
  parameter logic [31:0] KEY_FIRST = `CFGLK_KEY_FIRST_VAL,
  parameter logic [31:0] KEY_SECOND = `CFGLK_KEY_SECOND_VAL
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire cfglk_req_s req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic wr_blocked_o,
  output logic unlocked_o
);
  // Lock state and the two key-seen flags.
  cfglk_state_e state_q;
  cfglk_state_e state_d;
  logic first_ok_q;
  logic first_ok_d;
  logic second_ok_q;
  logic second_ok_d;
  // Read data from the bank and the key words.
  logic [31:0] bank_rdata;
  logic [31:0] key_rdata_q;
  logic key_rd_q;
  logic rvalid_q;
  logic wr_blocked_q;

  // Decode of the access.
  wire logic is_wr = req_i.valid && req_i.write;
  wire logic is_rd = req_i.valid && !req_i.write;
  wire logic hit_first = (req_i.addr == `CFGLK_KEY_FIRST_IDX);
  wire logic hit_second = (req_i.addr == `CFGLK_KEY_SECOND_IDX);
  wire logic hit_bank = (req_i.addr < 6'(`CFGLK_NWORDS));
  wire logic [15:0] wr_mask = `CFGLK_WR_MASK;
  wire logic word_writable = hit_bank && wr_mask[req_i.addr[3:0]];
  wire logic first_good = is_wr && hit_first && (req_i.wdata == KEY_FIRST);
  wire logic second_good = is_wr && hit_second && (req_i.wdata == KEY_SECOND);
  wire logic key_bad = is_wr && ((hit_first && (req_i.wdata != KEY_FIRST)) ||
                                 (hit_second && (req_i.wdata != KEY_SECOND)));
  // Writes reach the bank only while open and only to writable words.
  wire logic bank_we = is_wr && (state_q == CFGLK_OPEN) && word_writable;
  wire logic wr_refused = is_wr && hit_bank && !bank_we;

  // Lock sequencing; a single instance serves every core, so one state suffices.
  always_comb begin
    state_d = state_q;
    first_ok_d = first_ok_q;
    second_ok_d = second_ok_q;
    case (state_q)
      CFGLK_LOCKED: begin
        // Each key is remembered until its partner arrives, in either order.
        if (first_good) begin
          first_ok_d = 1'b1;
        end else if (second_good) begin
          second_ok_d = 1'b1;
        end else if (key_bad) begin
          // A wrong key restarts the sequence so stray writes cannot combine.
          first_ok_d = 1'b0;
          second_ok_d = 1'b0;
        end
        if (first_ok_d && second_ok_d) begin
          state_d = CFGLK_OPEN;
        end
      end
      CFGLK_OPEN: begin
        // Any differing key value closes the bank for every core.
        if (key_bad) begin
          state_d = CFGLK_LOCKED;
          first_ok_d = 1'b0;
          second_ok_d = 1'b0;
        end
      end
      default: begin
        state_d = CFGLK_LOCKED;
      end
    endcase
  end

  // State registers; reset always lands in the locked state.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= CFGLK_LOCKED;
      first_ok_q <= 1'b0;
      second_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      first_ok_q <= first_ok_d;
      second_ok_q <= second_ok_d;
    end
  end

  // Read path side registers: key words read back as zero to hide the keys.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      key_rdata_q <= 32'h0000_0000;
      key_rd_q <= 1'b0;
      rvalid_q <= 1'b0;
      wr_blocked_q <= 1'b0;
    end else begin
      // Only a read moves the select, so rdata_o holds the last answer until the next read.
      if (is_rd) begin
        key_rd_q <= !hit_bank;
      end
      key_rdata_q <= 32'h0000_0000;
      rvalid_q <= is_rd;
      wr_blocked_q <= wr_refused;
    end
  end

  // The bank itself; reads are served regardless of lock state.
  cfglk_bank u_bank (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .we_i(bank_we),
    .addr_i(req_i.addr[3:0]),
    .wdata_i(req_i.wdata),
    .re_i(is_rd && hit_bank),
    .rdata_o(bank_rdata)
  );

  assign rdata_o = key_rd_q ? key_rdata_q : bank_rdata;
  assign rvalid_o = rvalid_q;
  assign wr_blocked_o = wr_blocked_q;
  assign unlocked_o = (state_q == CFGLK_OPEN);

  // Locked bank never passes a write.
  property p_locked_no_write;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state_q == CFGLK_LOCKED) |-> !bank_we;
  endproperty
  a_locked_no_write: assert property (p_locked_no_write)
    else $error("write reached bank while locked");

  // A bank write refused while locked is flagged on the next cycle.
  property p_refused_flag;
    @(posedge clk_sys_i) disable iff (reset_i)
      (is_wr && hit_bank && (state_q == CFGLK_LOCKED)) |=> wr_blocked_o;
  endproperty
  a_refused_flag: assert property (p_refused_flag)
    else $error("locked write not flagged");

  // Read-only words never take a write.
  property p_ro_words;
    @(posedge clk_sys_i) disable iff (reset_i)
      (is_wr && hit_bank && !word_writable) |-> !bank_we;
  endproperty
  a_ro_words: assert property (p_ro_words)
    else $error("read-only word written");

  // Open bank accepts writable words.
  property p_open_writes;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state_q == CFGLK_OPEN && is_wr && word_writable) |-> bank_we;
  endproperty
  a_open_writes: assert property (p_open_writes)
    else $error("open bank refused writable word");

  // Opening only follows a good key write with its partner already seen.
  property p_open_cause;
    @(posedge clk_sys_i) disable iff (reset_i)
      $rose(unlocked_o) |-> $past(first_good && second_ok_q) ||
                            $past(second_good && first_ok_q);
  endproperty
  a_open_cause: assert property (p_open_cause)
    else $error("unlock without both keys");

  // Both keys in a row, either order, open the bank.
  property p_two_keys_open;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state_q == CFGLK_LOCKED && !key_bad && (first_good && second_ok_q ||
       second_good && first_ok_q)) |=> unlocked_o;
  endproperty
  a_two_keys_open: assert property (p_two_keys_open)
    else $error("good key pair did not unlock");

  // A wrong key while open relocks on the next edge.
  property p_relock;
    @(posedge clk_sys_i) disable iff (reset_i)
      (unlocked_o && key_bad) |=> !unlocked_o && !first_ok_q && !second_ok_q;
  endproperty
  a_relock: assert property (p_relock)
    else $error("bad key did not relock");

  // Unlocked state stays put without a bad key.
  property p_open_holds;
    @(posedge clk_sys_i) disable iff (reset_i)
      (unlocked_o && !key_bad) |=> unlocked_o;
  endproperty
  a_open_holds: assert property (p_open_holds)
    else $error("lock changed without cause");

  // Straight out of reset the bank is locked.
  property p_reset_locked;
    @(posedge clk_sys_i)
      $fell(reset_i) |-> !unlocked_o;
  endproperty
  a_reset_locked: assert property (p_reset_locked)
    else $error("bank open after reset");

  // A lone first key never opens the bank; its partner must already have been seen.
  property p_lone_key;
    @(posedge clk_sys_i) disable iff (reset_i)
      (state_q == CFGLK_LOCKED && first_good && !second_ok_q) |=> !unlocked_o;
  endproperty
  a_lone_key: assert property (p_lone_key)
    else $error("single key opened the bank");

  // Every read is answered on the next edge, whether the bank is locked or open.
  property p_read_answer;
    @(posedge clk_sys_i) disable iff (reset_i)
      is_rd |=> rvalid_o;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");
endmodule // cfglk_top

/* core/cfglk_map.svh */
`ifndef CFGLK_MAP_SVH
`define CFGLK_MAP_SVH

// Word address width of the configuration bank.
`define CFGLK_AW 6
// Number of words in the protected bank.
`define CFGLK_NWORDS 16
// Word index of the first key register.
`define CFGLK_KEY_FIRST_IDX 6'h38
// Word index of the second key register.
`define CFGLK_KEY_SECOND_IDX 6'h39
// Default key values; these values are arbitrary.
`define CFGLK_KEY_FIRST_VAL 32'h1234_5678
`define CFGLK_KEY_SECOND_VAL 32'hcafe_f00d
// Reset value of every bank word.
`define CFGLK_WORD_RESET 32'h0000_0000
// Default write-permission mask: words 0 to 11 writable, 12 to 15 read-only.
`define CFGLK_WR_MASK 16'h0fff

`endif

/* core/cfglk_pkg.sv */
package cfglk_pkg;
  // One configuration bus access, carried as a group.
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] addr;
    logic [31:0] wdata;
  } cfglk_req_s;
  // Lock state shared by every core on the bus.
  typedef enum logic {
    CFGLK_LOCKED,
    CFGLK_OPEN
  } cfglk_state_e;
endpackage

/* core/cfglk_bank.sv */
`timescale 1ns/1ps
`include "cfglk_map.svh"

// Small register bank: one write port gated by the caller, registered read data.
module cfglk_bank (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic we_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic re_i,
  output logic [31:0] rdata_o
);
  // Storage words; kept in flops so reset can clear them.
  logic [31:0] mem_q [`CFGLK_NWORDS];

  // One flop group per word, written only when addressed and enabled.
  genvar gi;
  generate
    for (gi = 0; gi < `CFGLK_NWORDS; gi++) begin : g_word
      always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
          mem_q[gi] <= `CFGLK_WORD_RESET;
        end else if (we_i && (addr_i == 4'(gi))) begin
          mem_q[gi] <= wdata_i;
        end
      end
    end
  endgenerate

  // Read data is registered, so reads answer one cycle after the request.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (re_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule // cfglk_bank

/* testbench/cfglk_master_model.sv */
`timescale 1ns/1ps
// Bus master standing in for the cores; it changes requests on the falling edge only.
module cfglk_master_model
  import cfglk_pkg::*;
(
  input wire logic clk_sys_i,
  output cfglk_req_s req_o
);
  int seed = 19; // Fixed seed, so idle garbage repeats from run to run.
  initial req_o = '0;
  // One access, held across the rising edge that takes it; callers may chain them.
  task automatic access(input logic wr, input logic [5:0] addr, input logic [31:0] data);
    req_o <= '{valid: 1'b1, write: wr, addr: addr, wdata: data};
    @(negedge clk_sys_i);
  endtask
  // Idle drops valid, holds write high and scrambles address and data, so a stale field is never mistaken for a request.
  task automatic idle();
    req_o <= '{valid: 1'b0, write: 1'b1, addr: 6'($random(seed)), wdata: 32'($random(seed))};
    @(negedge clk_sys_i);
  endtask
endmodule // cfglk_master_model

/* testbench/cfglk_top_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench: the driver notes each expected answer, a watcher compares it.
module cfglk_top_tb_top
  import cfglk_pkg::*;
;
  localparam logic [31:0] K1 = 32'h0bad_1dea; // Arbitrary key value.
  localparam logic [31:0] K2 = 32'h7e57_c0de; // Arbitrary key value.
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  cfglk_req_s req;
  logic [31:0] rdata_o;
  logic rvalid_o;
  logic wr_blocked_o;
  logic unlocked_o;
  logic [32:0] exp_q[$]; // Notes: {refused, read data}.
  logic [31:0] mem[16]; // Expected bank contents.
  logic open_exp = 1'b0; // Expected lock state.
  int fails = 0;
  int total_checks = 0;
  int seed = 19;
  always #2 clk_sys_i = ~clk_sys_i;
  cfglk_master_model m (.clk_sys_i(clk_sys_i), .req_o(req));
  cfglk_top #(.KEY_FIRST(K1), .KEY_SECOND(K2)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .req_i(req), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wr_blocked_o(wr_blocked_o),
    .unlocked_o(unlocked_o));
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Watcher samples on the falling edge, when the registered answers have settled.
  always @(negedge clk_sys_i) begin
    if (rvalid_o === 1'b1 || wr_blocked_o === 1'b1) begin
      if (exp_q.size() == 0) check({wr_blocked_o, rdata_o}, 33'bx);
      else check({wr_blocked_o, wr_blocked_o ? 32'h0 : rdata_o}, exp_q.pop_front());
    end
  end
  // A write is refused for any bank word while locked, and for read-only words always.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    if (a < 6'h10 && (!open_exp || a >= 6'h0c)) exp_q.push_back({1'b1, 32'h0});
    else if (a < 6'h10) mem[a[3:0]] = d;
    m.access(1'b1, a, d);
  endtask
  // Keys and other unmapped words read back as zero.
  task automatic rd(input logic [5:0] a);
    exp_q.push_back({1'b0, a < 6'h10 ? mem[a[3:0]] : 32'h0});
    m.access(1'b0, a, 32'h0);
  endtask
  // One idle cycle lets a deciding key write reach the lock state first.
  task automatic lk(input logic e);
    m.idle();
    check({32'h0, unlocked_o}, {32'h0, e});
  endtask
  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch.
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (10) @(negedge clk_sys_i);
    reset_i = 1'b0;
    lk(1'b0);
    rd(6'h03);
    wr(6'h03, $random(seed));
    rd(6'h03);
    $display("test locked_after_reset done");
    // A lone key, then a wrong key that wipes progress, must not open the bank.
    wr(6'h38, K1);
    lk(1'b0);
    wr(6'h39, ~K2);
    wr(6'h39, K2);
    lk(1'b0);
    $display("test partial_unlock done");
    wr(6'h39, K2);
    wr(6'h38, K1);
    lk(1'b1);
    open_exp = 1'b1;
    for (int i = 0; i < 16; i++) wr(6'(i), $random(seed));
    for (int i = 0; i < 16; i++) rd(6'(i));
    rd(6'h38);
    $display("test open_bank done");
    wr(6'h38, K1 ^ 32'h1);
    lk(1'b0);
    open_exp = 1'b0;
    wr(6'h00, $random(seed));
    rd(6'h00);
    $display("test relock done");
    wr(6'h38, K1);
    wr(6'h39, K2);
    lk(1'b1);
    open_exp = 1'b1;
    wr(6'h05, $random(seed));
    rd(6'h05);
    $display("test unlock_again done");
    // A reset in mid-run must close the open bank and clear word 5.
    for (int i = 0; i < 8 && exp_q.size() > 0; i++) m.idle();
    reset_i = 1'b1;
    foreach (mem[i]) mem[i] = 32'h0;
    open_exp = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    lk(1'b0);
    rd(6'h05);
    $display("test mid_run_reset done");
    // A wrong value in the second key register relocks the bank as well.
    wr(6'h38, K1);
    wr(6'h39, K2);
    lk(1'b1);
    wr(6'h39, ~K2);
    lk(1'b0);
    wr(6'h05, $random(seed));
    rd(6'h05);
    $display("test relock_second done");
    for (int i = 0; i < 8 && exp_q.size() > 0; i++) m.idle();
    // Every noted answer must have appeared by now.
    check(33'(exp_q.size()), 33'h0);
    give_verdict();
  end
endmodule // cfglk_top_tb_top
